// File: sdp_asserts.sv
// port-level assertions for the shared display port
`timescale 1ns/10ps
`default_nettype none
`include "sdp_defs.vh"
module sdp_chk (
   // clock and reset
   input wire logic                  i_core_clk,
   input wire logic                  i_rst,
   // watched inputs
   input wire logic                  i_display_owner_select,
   input wire logic                  i_app_display_select,
   input wire logic                  i_bc_display_select,
   input wire logic                  i_app_polarity_toggle_pulse,
   // watched outputs
   input wire logic                  o_owner_app,
   input wire logic                  o_line_written,
   input wire logic [`SDP_ROW_W-1:0] o_last_row,
   input wire logic                  o_polarity
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // ownership follows the select pin once it has settled
   AST_OWN_APP: assert property (i_display_owner_select [*4] |=> o_owner_app)
      else $error("owner flag not high");
   AST_OWN_BC: assert property (!i_display_owner_select [*4] |=> !o_owner_app)
      else $error("owner flag not low");
   // a stored line is flagged for one cycle only
   AST_PULSE: assert property (o_line_written |=> !o_line_written)
      else $error("line pulse too long");
   // no line is stored while both selects stay low
   AST_IDLE: assert property ((!i_app_display_select && !i_bc_display_select) [*8]
      |-> !o_line_written)
      else $error("line stored without select");
   // the row index moves only with a stored line
   AST_ROW: assert property ($changed(o_last_row) |-> o_line_written)
      else $error("row index moved alone");
   // while the app owns, a quiet app pulse leaves polarity alone
   AST_POL: assert property ((o_owner_app && !i_app_polarity_toggle_pulse) [*5]
      |=> $stable(o_polarity))
      else $error("polarity moved without owner pulse");
   cover property (o_line_written);
   cover property ($rose(o_owner_app));
   cover property ($changed(o_polarity));
endmodule
bind sdp_top sdp_chk u_chk (.i_core_clk, .i_rst, .i_display_owner_select,
   .i_app_display_select, .i_bc_display_select, .i_app_polarity_toggle_pulse,
   .o_owner_app, .o_line_written, .o_last_row, .o_polarity);
`default_nettype wire

// File: sdp_defs.vh
// constants for the shared display port
`ifndef SDP_DEFS_VH
`define SDP_DEFS_VH

`define SDP_LINE_BITS      128
`define SDP_LINE_CNT_W     8
`define SDP_ROWS           128
`define SDP_ROW_W          7
`define SDP_SYNC_W         2

`endif

// File: sdp_line_latch.v
// line store: shifts serial bits in while selected, keeps the last whole line
`timescale 1ns/10ps
`default_nettype none
`include "sdp_defs.vh"

module sdp_line_latch (
   // clock and reset
   input  wire                          i_core_clk,
   input  wire                          i_rst,
   // sampled serial strobes
   input  wire                          i_sel,
   input  wire                          i_clk_rise,
   input  wire                          i_data,
   // captured line
   output reg                           o_line_done,
   output reg  [`SDP_LINE_BITS-1:0]     o_line
);

   reg [`SDP_LINE_BITS-1:0]   shift_reg;
   reg [`SDP_LINE_CNT_W-1:0]  cnt_reg;

   // -------------------------------------------------------------------
   // shift and line capture
   // -------------------------------------------------------------------
   // bits enter only while selected; a drop of select discards a partial line
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         shift_reg   <= {`SDP_LINE_BITS{1'b0}};
         cnt_reg     <= {`SDP_LINE_CNT_W{1'b0}};
         o_line      <= {`SDP_LINE_BITS{1'b0}};
         o_line_done <= 1'b0;
      end else begin
         o_line_done <= 1'b0;
         if (!i_sel) begin
            cnt_reg <= {`SDP_LINE_CNT_W{1'b0}};
         end else if (i_clk_rise) begin
            shift_reg <= {shift_reg[`SDP_LINE_BITS-2:0], i_data};
            if (cnt_reg == `SDP_LINE_BITS - 1) begin
               cnt_reg     <= {`SDP_LINE_CNT_W{1'b0}};
               o_line      <= {shift_reg[`SDP_LINE_BITS-2:0], i_data};
               o_line_done <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 8'h01;
            end
         end
      end
   end

endmodule
`default_nettype wire

// File: sdp_side_drv.sv
// pin model of one display driver side
`timescale 1ns/10ps
`default_nettype none
module sdp_side_drv (
   // clock and ownership
   input  wire logic i_core_clk,
   input  wire logic i_own,
   // display pins
   output var logic  o_sel = 1'b0,
   output var logic  o_sclk = 1'b0,
   output var logic  o_si = 1'b0,
   output var logic  o_pol = 1'b0
);
   int cnt = 1000; // starts mid-gap so no pulse falls inside reset
   // idle data line toggles; pulse only while owning
   always @(negedge i_core_clk) begin
      cnt <= cnt + 1;
      o_pol <= i_own && (cnt % 2000 < 8);
      if (!o_sel)
         o_si <= ~o_si;
   end
   // send nbits of a line msb first, clock under 1.1 MHz
   task automatic send(input logic [127:0] line, input int nbits);
      @(negedge i_core_clk) o_sel = 1'b1;
      for (int b = 127; b > 127 - nbits; b--) begin
         @(negedge i_core_clk) o_si = line[b];
         repeat (115) @(negedge i_core_clk);
         o_sclk = 1'b1;
         repeat (115) @(negedge i_core_clk);
         o_sclk = 1'b0;
      end
      repeat (3) @(negedge i_core_clk);
      o_sel = 1'b0;
      repeat (4) @(negedge i_core_clk);
   endtask
endmodule
`default_nettype wire

// File: sdp_top.v
// shared display port: ownership mux, line receiver and pixel store
`timescale 1ns/10ps
`default_nettype none
`include "sdp_defs.vh"

// Functional notes
// - with ownership select low the board controller's display signals are routed through.
// - with ownership select high the target application's display signals are routed through.
// - serial bits shift in only while display select is high, clocked by the serial clock.
// - the panel keeps the last written line data without any refresh traffic.
// - the panel holds 128 x 128 single-bit pixels, light or dark.
module sdp_top (
   // clock and reset
   input  wire                          i_core_clk,
   input  wire                          i_rst,
   // ownership select from the target application
   input  wire                          i_display_owner_select,
   // target application display pins
   input  wire                          i_app_display_select,
   input  wire                          i_app_display_serial_clock,
   input  wire                          i_app_display_serial_in,
   input  wire                          i_app_polarity_toggle_pulse,
   // board controller display pins
   input  wire                          i_bc_display_select,
   input  wire                          i_bc_display_serial_clock,
   input  wire                          i_bc_display_serial_in,
   input  wire                          i_bc_polarity_toggle_pulse,
   // row read port
   input  wire [`SDP_ROW_W-1:0]         i_row_addr,
   output reg  [`SDP_LINE_BITS-1:0]     o_row_data,
   // status
   output reg                           o_owner_app,
   output reg                           o_line_written,
   output reg  [`SDP_ROW_W-1:0]         o_last_row,
   output reg                           o_polarity
);

   // -------------------------------------------------------------------
   // storage and internal nets
   // -------------------------------------------------------------------
   // two-stage synchronisers, one per pin; bit 0 is the metastable stage
   reg  [`SDP_SYNC_W-1:0]     own_s_reg;     // ownership select
   reg  [`SDP_SYNC_W-1:0]     as_s_reg;      // app display select
   reg  [`SDP_SYNC_W-1:0]     ak_s_reg;      // app serial clock
   reg  [`SDP_SYNC_W-1:0]     ad_s_reg;      // app serial data
   reg  [`SDP_SYNC_W-1:0]     ap_s_reg;      // app polarity pulse
   reg  [`SDP_SYNC_W-1:0]     bs_s_reg;      // controller display select
   reg  [`SDP_SYNC_W-1:0]     bk_s_reg;      // controller serial clock
   reg  [`SDP_SYNC_W-1:0]     bd_s_reg;      // controller serial data
   reg  [`SDP_SYNC_W-1:0]     bp_s_reg;      // controller polarity pulse
   // one-cycle history of the routed strobes
   reg                        sclk_d_reg;    // serial clock seen last cycle
   reg                        pol_d_reg;     // polarity pulse seen last cycle
   reg                        sel_d_reg;     // select, cleared across an owner change
   // row bookkeeping and the panel image itself
   reg  [`SDP_ROW_W-1:0]      row_ptr_reg;   // row the next line lands in
   reg  [`SDP_LINE_BITS-1:0]  pixels [0:`SDP_ROWS-1];

   // routed pin levels after the ownership mux
   wire                       owner_app;
   wire                       m_sel;
   wire                       m_sclk;
   wire                       m_data;
   wire                       m_pol;
   // derived strobes and next values
   wire                       sclk_rise;
   wire                       pol_rise;
   wire                       latch_sel;
   wire [`SDP_ROW_W-1:0]      row_ptr_next;
   // line receiver results
   wire                       line_done;
   wire [`SDP_LINE_BITS-1:0]  line;

   // returns the synchronised level
   function sync_out;
      input [`SDP_SYNC_W-1:0] s;
      begin
         sync_out = s[`SDP_SYNC_W-1];
      end
   endfunction

   // routes one pin level from whichever side owns the display
   function pick_side;
      input app_owns;
      input app_level;
      input bc_level;
      begin
         pick_side = app_owns ? app_level : bc_level;
      end
   endfunction

   // true on the first cycle a sampled level is seen high
   function rise_of;
      input now_level;
      input last_level;
      begin
         rise_of = now_level & ~last_level;
      end
   endfunction

   // -------------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------------
   // the first stage feeds only the second
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         own_s_reg <= 2'h0;
         as_s_reg  <= 2'h0;
         ak_s_reg  <= 2'h0;
         ad_s_reg  <= 2'h0;
         ap_s_reg  <= 2'h0;
         bs_s_reg  <= 2'h0;
         bk_s_reg  <= 2'h0;
         bd_s_reg  <= 2'h0;
         bp_s_reg  <= 2'h0;
      end else begin
         own_s_reg <= {own_s_reg[0], i_display_owner_select};
         as_s_reg  <= {as_s_reg[0], i_app_display_select};
         ak_s_reg  <= {ak_s_reg[0], i_app_display_serial_clock};
         ad_s_reg  <= {ad_s_reg[0], i_app_display_serial_in};
         ap_s_reg  <= {ap_s_reg[0], i_app_polarity_toggle_pulse};
         bs_s_reg  <= {bs_s_reg[0], i_bc_display_select};
         bk_s_reg  <= {bk_s_reg[0], i_bc_display_serial_clock};
         bd_s_reg  <= {bd_s_reg[0], i_bc_display_serial_in};
         bp_s_reg  <= {bp_s_reg[0], i_bc_polarity_toggle_pulse};
      end
   end

   // -------------------------------------------------------------------
   // ownership mux
   // -------------------------------------------------------------------
   // the side not selected is ignored entirely, so its lines cannot disturb
   assign owner_app = sync_out(own_s_reg);
   // both sides pass the same two flops, so a swap of owner moves all four
   // routed levels on the same edge; on the next edge sel_d_reg and sclk_d_reg still carry the old owner's levels
   assign m_sel  = pick_side(owner_app, sync_out(as_s_reg),
                             sync_out(bs_s_reg));
   assign m_sclk = pick_side(owner_app, sync_out(ak_s_reg),
                             sync_out(bk_s_reg));
   assign m_data = pick_side(owner_app, sync_out(ad_s_reg),
                             sync_out(bd_s_reg));
   assign m_pol  = pick_side(owner_app, sync_out(ap_s_reg),
                             sync_out(bp_s_reg));

   // -------------------------------------------------------------------
   // edge history
   // -------------------------------------------------------------------
   // a change of owner forces select low for a cycle, closing any open line;
   // without it the new owner could finish a line the old owner had begun,
   // mixing bits of two drivers in one row
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sclk_d_reg  <= 1'b0;
         pol_d_reg   <= 1'b0;
         sel_d_reg   <= 1'b0;
         o_owner_app <= 1'b0;
      end else begin
         sclk_d_reg  <= m_sclk;
         pol_d_reg   <= m_pol;
         sel_d_reg   <= m_sel & (owner_app == o_owner_app);
         o_owner_app <= owner_app;
      end
   end

   // strobes from the history; select must have stood one cycle already
   assign sclk_rise = rise_of(m_sclk, sclk_d_reg);
   assign pol_rise  = rise_of(m_pol, pol_d_reg);
   assign latch_sel = sel_d_reg & m_sel;

   // -------------------------------------------------------------------
   // line receiver
   // -------------------------------------------------------------------
   // a partial line left by a drop of select never reaches the store
   sdp_line_latch u_latch (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_sel       (latch_sel),
      .i_clk_rise  (sclk_rise),
      .i_data      (m_data),
      .o_line_done (line_done),
      .o_line      (line)
   );

   // -------------------------------------------------------------------
   // pixel store
   // -------------------------------------------------------------------
   // lines fill rows in turn and stay until overwritten, no refresh needed
   always @(posedge i_core_clk) begin
      if (line_done) begin
         pixels[row_ptr_reg] <= line;
      end
      o_row_data <= pixels[i_row_addr];
   end

   // -------------------------------------------------------------------
   // row pointer and status
   // -------------------------------------------------------------------
   // the row after the current one; 128 rows wrap naturally in 7 bits
   assign row_ptr_next = row_ptr_reg + 7'h01;

   // row pointer and line strobe advance together with each stored line
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         row_ptr_reg    <= 7'h00;
         o_last_row     <= 7'h00;
         o_line_written <= 1'b0;
      end else begin
         o_line_written <= line_done;
         if (line_done) begin
            o_last_row  <= row_ptr_reg;
            row_ptr_reg <= row_ptr_next;
         end
      end
   end

   // polarity state flips on each rise of the owner's pulse; a quiet owner
   // leaves it alone, which is all the panel needs between pulses
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_polarity <= 1'b0;
      end else if (pol_rise) begin
         o_polarity <= ~o_polarity;
      end
   end

endmodule
`default_nettype wire

// File: testbench.sv
// self-checking testbench for the shared display port
`timescale 1ns/10ps
`default_nettype none
`include "sdp_defs.vh"
module testbench;
   logic                  i_core_clk = 1'b0;
   logic                  i_rst = 1'b1;
   logic                  own = 1'b0;
   logic [6:0]            i_row_addr = 7'h00;
   wire logic             a_sel, a_clk, a_si, a_pol, b_sel, b_clk, b_si, b_pol;
   wire logic [127:0]     o_row_data;
   wire logic             o_owner_app, o_line_written, o_polarity;
   wire logic [6:0]       o_last_row;
   logic [127:0]          lines [3];
   logic [6:0]            exp_q [$];
   int                    err_count = 0;
   int                    total_checks = 0;
   int                    seed = 7;
   logic                  pol_prev = 1'b0;
   logic                  exp_pol = 1'b0;
   logic                  pol_seen = 1'b0;
   logic                  exp_pol_q [$];
   sdp_side_drv u_app (.i_core_clk, .i_own(own), .o_sel(a_sel), .o_sclk(a_clk),
      .o_si(a_si), .o_pol(a_pol));
   sdp_side_drv u_bc (.i_core_clk, .i_own(!own), .o_sel(b_sel), .o_sclk(b_clk),
      .o_si(b_si), .o_pol(b_pol));
   sdp_top dut (.i_core_clk, .i_rst, .i_display_owner_select(own),
      .i_app_display_select(a_sel), .i_app_display_serial_clock(a_clk),
      .i_app_display_serial_in(a_si), .i_app_polarity_toggle_pulse(a_pol),
      .i_bc_display_select(b_sel), .i_bc_display_serial_clock(b_clk),
      .i_bc_display_serial_in(b_si), .i_bc_polarity_toggle_pulse(b_pol),
      .i_row_addr, .o_row_data, .o_owner_app, .o_line_written, .o_last_row, .o_polarity);
   // compare and count
   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial forever #2 i_core_clk = ~i_core_clk;
   // each stored line takes the oldest expected row
   always @(negedge i_core_clk) begin
      if (o_line_written === 1'b1) begin
         if (exp_q.size() == 0)
            chk("stray line", 128'h1, 128'h0);
         else
            chk("last row", 128'(o_last_row), 128'(exp_q.pop_front()));
      end
      // each polarity change takes the oldest expected level
      if (o_polarity !== pol_seen) begin
         pol_seen = o_polarity;
         if (exp_pol_q.size() == 0)
            chk("stray polarity", 128'h1, 128'h0);
         else
            chk("polarity", 128'(o_polarity), 128'(exp_pol_q.pop_front()));
      end
   end
   // each rise of the owner's pulse pin notes the polarity level to follow
   always @(negedge i_core_clk) begin
      pol_prev <= own ? a_pol : b_pol;
      if ((own ? a_pol : b_pol) && !pol_prev) begin
         exp_pol = ~exp_pol;
         exp_pol_q.push_back(exp_pol);
      end
   end
   initial begin
      repeat (6) @(negedge i_core_clk);
      i_rst = 1'b0;
      for (int i = 0; i < 3; i++)
         lines[i] = {$random(seed), $random(seed), $random(seed), $random(seed)};
      exp_q.push_back(7'h00);
      u_bc.send(lines[0], 128);
      own = 1'b1;
      repeat (8) @(negedge i_core_clk);
      chk("owner", 128'(o_owner_app), 128'h1);
      exp_q.push_back(7'h01);
      fork
         u_app.send(lines[1], 128);
         u_bc.send(~lines[1], 128);
      join
      u_app.send(lines[0], 30);
      exp_q.push_back(7'h02);
      u_app.send(lines[2], 128);
      for (int r = 0; r < 3; r++) begin
         i_row_addr = 7'(r);
         repeat (2) @(negedge i_core_clk);
         chk("row data", o_row_data, lines[r]);
      end
      chk("pending rows", 128'(exp_q.size()), 128'h0);
      // stop mid-gap between pulses so none is still in flight
      while ((u_app.cnt % 2000) != 1000)
         @(negedge i_core_clk);
      chk("pending pulses", 128'(exp_pol_q.size()), 128'h0);
      end_of_test();
   end
   // hang guard
   initial begin
      #440000;
      err_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
